// ==== hw/mqf_pkg.sv ====
// ---------------------------------------------------------------------------
// Shared constants for the queue flag block.
// ---------------------------------------------------------------------------
package mqf_pkg;
  // Width of each queue select bus.
  localparam int MQF_SEL_W = 8;
  // Width of the device index code taken from the top select bits.
  localparam int MQF_IDX_W = 3;
  // Words a queue holds before it reads as full.
  localparam int MQF_DEPTH = 64;
  // Edges from a selection edge to the flag output showing the new queue.
  localparam int MQF_FLAG_LAT = 3;
  // Edges from a selection edge to the committed selection register.
  localparam int MQF_SEL_LAT = 2;
  // Flag level after reset: inactive, since both flags are active low.
  localparam logic MQF_FLAG_RST = 1'b1;
  // Output enable after reset: released, the line is not driven.
  localparam logic MQF_OE_N_RST = 1'b1;
endpackage : mqf_pkg

// ==== hw/mqf_status_if.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Link between the flag controller and the per-queue status store.
// ---------------------------------------------------------------------------
interface mqf_status_if #(
  parameter int QA_W = 5,
  parameter int CNT_W = 7
) ();
  logic inc_en;
  logic [QA_W-1:0] inc_idx;
  logic dec_en;
  logic [QA_W-1:0] dec_idx;
  logic [QA_W-1:0] wr_addr;
  logic [QA_W-1:0] rd_addr;
  logic full_w;
  logic empty_r;

  modport mem (
    input inc_en, inc_idx, dec_en, dec_idx, wr_addr, rd_addr,
    output full_w, empty_r
  );
  modport ctl (
    output inc_en, inc_idx, dec_en, dec_idx, wr_addr, rd_addr,
    input full_w, empty_r
  );
endinterface : mqf_status_if

// ==== hw/mqf_status_mem.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Occupancy store: one word count per local queue, registered status reads.
// ---------------------------------------------------------------------------
module mqf_status_mem
  import mqf_pkg::*;
#(
  parameter int NQ = 32,
  parameter int QA_W = 5,
  parameter int DEPTH = MQF_DEPTH,
  parameter int CNT_W = 7
) (
  input wire logic clk_i,   // System clock.
  input wire logic reset_i, // Synchronous reset, active high.
  mqf_status_if.mem st      // Count updates and status reads.
);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEPTH);

  logic [CNT_W-1:0] count [NQ];
  logic [CNT_W-1:0] next_count [NQ];
  logic next_full_w;
  logic next_empty_r;
  logic full_w_q;
  logic empty_r_q;

  // Every queue keeps its own count, so status moves even when the queue
  // is not the one shown on a flag.
  for (genvar g = 0; g < NQ; g++)
  begin : g_cnt
    logic up;
    logic dn;
    always_comb
    begin
      up = st.inc_en && (st.inc_idx == QA_W'(g)) && (count[g] != CNT_MAX);
      dn = st.dec_en && (st.dec_idx == QA_W'(g)) && (count[g] != '0);
      next_count[g] = count[g];
      if (up && !dn)
        next_count[g] = count[g] + CNT_W'(1); // [R1]
      else if (dn && !up)
        next_count[g] = count[g] - CNT_W'(1); // [R5]
    end
  end

  // Read ports look up the addressed counts; a same-cycle update shows
  // one edge later, which the flag pipeline absorbs.
  always_comb
  begin
    next_full_w = (count[st.wr_addr] == CNT_MAX);
    next_empty_r = (count[st.rd_addr] == '0);
  end

  // Registers for counts and read data.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      count <= '{default: '0};
      full_w_q <= 1'b0;
      empty_r_q <= 1'b1;
    end
    else
    begin
      count <= next_count;
      full_w_q <= next_full_w;
      empty_r_q <= next_empty_r;
    end
  end

  assign st.full_w = full_w_q;
  assign st.empty_r = empty_r_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] inc_cur;
  logic [CNT_W-1:0] dec_cur;
  assign inc_cur = count[st.inc_idx];
  assign dec_cur = count[st.dec_idx];

  count_bound_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (reset_i)
    (inc_cur <= CNT_MAX))
    else $error("queue count above depth");

  inc_step_a: assert property ( // [R1]
    @(posedge clk_i) disable iff (reset_i)
    (st.inc_en && !st.dec_en && inc_cur != CNT_MAX) |=>
    (count[$past(st.inc_idx)] == $past(inc_cur) + 1'b1))
    else $error("write did not raise queue count");

  dec_step_a: assert property ( // [R5]
    @(posedge clk_i) disable iff (reset_i)
    (st.dec_en && !st.inc_en && dec_cur != '0) |=>
    (count[$past(st.dec_idx)] == $past(dec_cur) - 1'b1))
    else $error("read did not lower queue count");
endmodule : mqf_status_mem

// ==== hw/mqf_flags.sv ====
`timescale 1ns/1ps
// How it works
// [R1] Full status kept per queue; only the write-selected queue drives the full flag.
// [R2] Full flag shows a newly selected write queue on the third edge after selection.
// [R3] Writes to the new queue count from the fourth edge after selection.
// [R4] Full flag changes only on a rising clock edge.
// [R5] Reads lower the full status of queues not selected for writing.
// [R6] Full flag released when none of this device's queues is write-selected.
// [R7] Write switches inside this device keep the full flag driven and updated.
// [R8] Index code is one to three top select bits, at most 256 queues.
// [R9] Full flag driven only when top write select bits equal the index straps.
// [R10] Controller ties full flags together and writes one device at a time.
// [R11] Empty status per queue; empty flag updates on the read data load edge.
// [R12] Empty flag released when none of this device's queues is read-selected.
// [R13] Read switches inside this device keep the empty flag driven and updated.
// [R14] Empty flag driven only when top read select bits equal the index straps.
// [R15] Controller ties empty flags together and reads one device at a time.
// [R16] Read switch takes four cycles; empty flag updates in the third.
// [R17] Flags low for full or empty selected queue, high otherwise.
module mqf_flags
  import mqf_pkg::*;
#(
  parameter int SEL_W = MQF_SEL_W,
  parameter int IDX_W = MQF_IDX_W,
  parameter int DEPTH = MQF_DEPTH
) (
  input wire logic clk_i,                                // System clock.
  input wire logic reset_i,                              // Sync reset, high.
  input wire logic [SEL_W-1:0] write_queue_select_bus_i, // Write queue.
  input wire logic write_select_strobe_i,                // Take write select.
  input wire logic [SEL_W-1:0] read_queue_select_bus_i,  // Read queue.
  input wire logic read_select_strobe_i,                 // Take read select.
  input wire logic write_word_i,    // A word enters the write queue.
  input wire logic read_word_i,     // A word leaves the read queue.
  input wire logic device_index_strap0_i,                // Index bit 0.
  input wire logic device_index_strap1_i,                // Index bit 1.
  input wire logic device_index_strap2_i,                // Index bit 2.
  output logic queue_full_flag_n_o,     // Selected write queue full, low.
  output logic queue_full_flag_oe_n_o,  // Low while full flag is driven.
  output logic queue_empty_flag_n_o,    // Selected read queue empty, low.
  output logic queue_empty_flag_oe_n_o  // Low while empty flag is driven.
);
  // Local queue address width; the index code takes the top bits. [R8]
  localparam int QA_W = SEL_W - IDX_W;
  localparam int NQ = 2 ** QA_W;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int PIN_W = 2 * SEL_W + 7;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [SEL_W-1:0] wbus_s;
  logic [SEL_W-1:0] rbus_s;
  logic wstb_s;
  logic rstb_s;
  logic wword_s;
  logic rword_s;
  logic [2:0] strap_s;

  assign pin_raw = {write_queue_select_bus_i, write_select_strobe_i,
                    read_queue_select_bus_i, read_select_strobe_i,
                    write_word_i, read_word_i, device_index_strap2_i,
                    device_index_strap1_i, device_index_strap0_i};
  assign {wbus_s, wstb_s, rbus_s, rstb_s, wword_s, rword_s, strap_s} = pin_s2;

  // Two flops on every pin; only the second stage feeds logic.
  // The straps pass the same flops as the buses. They are static, so the
  // lag only matters just after reset, while no selection is owned and
  // both flag lines are released anyway.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // ---------------------------------------------------------------------------
  // Queue selection and status store
  // ---------------------------------------------------------------------------
  mqf_status_if #(.QA_W(QA_W), .CNT_W(CNT_W)) st ();

  mqf_status_mem #(
    .NQ(NQ),
    .QA_W(QA_W),
    .DEPTH(DEPTH),
    .CNT_W(CNT_W)
  ) u_mem (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .st(st.mem)
  );

  logic [SEL_W-1:0] wsel;
  logic [SEL_W-1:0] rsel;
  logic wsel_ok;
  logic rsel_ok;
  logic whit;
  logic rhit;
  logic [SEL_W-1:0] next_wsel;
  logic [SEL_W-1:0] next_rsel;
  logic next_wsel_ok;
  logic next_rsel_ok;
  logic next_whit;
  logic next_rhit;
  logic [IDX_W-1:0] code;

  // A strobed select replaces the held one; the store is addressed with
  // the incoming value so the lookup needs no extra cycle. [R2] [R16]
  always_comb
  begin
    code = strap_s[IDX_W-1:0];
    next_wsel = wstb_s ? wbus_s : wsel;
    next_rsel = rstb_s ? rbus_s : rsel;
    next_wsel_ok = wsel_ok | wstb_s;
    next_rsel_ok = rsel_ok | rstb_s;
    next_whit = next_wsel_ok && (next_wsel[SEL_W-1 -: IDX_W] == code); // [R9]
    next_rhit = next_rsel_ok && (next_rsel[SEL_W-1 -: IDX_W] == code); // [R14]
  end

  // Word events only count while this device owns the port. [R3] [R5]
  // A word sent to a full queue, or taken from an empty one, is dropped by
  // the store instead of wrapping the count; the controller should have
  // read the flag before it moved the word.
  assign st.wr_addr = next_wsel[QA_W-1:0];
  assign st.rd_addr = next_rsel[QA_W-1:0];
  assign st.inc_en = wword_s && whit; // [R3]
  assign st.inc_idx = wsel[QA_W-1:0];
  assign st.dec_en = rword_s && rhit; // [R5]
  assign st.dec_idx = rsel[QA_W-1:0];

  // Selection registers; nothing is owned until a first strobe arrives.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wsel <= '0;
      rsel <= '0;
      wsel_ok <= 1'b0;
      rsel_ok <= 1'b0;
      whit <= 1'b0;
      rhit <= 1'b0;
    end
    else
    begin
      wsel <= next_wsel;
      rsel <= next_rsel;
      wsel_ok <= next_wsel_ok;
      rsel_ok <= next_rsel_ok;
      whit <= next_whit;
      rhit <= next_rhit;
    end
  end

  // ---------------------------------------------------------------------------
  // Flag outputs
  // ---------------------------------------------------------------------------
  logic next_full_n;
  logic next_full_oe_n;
  logic next_empty_n;
  logic next_empty_oe_n;

  // Flag and its enable move together on one edge, so a shared line never
  // shows a stale queue from this device. The level drives the empty flag
  // in the same edge that the read data of the new queue would load.
  always_comb
  begin
    next_full_n = ~st.full_w;    // [R17] [R1]
    next_full_oe_n = ~whit;      // [R6] [R7] [R9]
    next_empty_n = ~st.empty_r;  // [R17] [R11]
    next_empty_oe_n = ~rhit;     // [R12] [R13] [R14]
  end

  // A word shows on its flag four edges after the edge that samples its
  // pin: the second pin flop, the count, the status read and the output
  // register each take one. A controller writing every edge must allow it.
  // Output registers; every transition lands on a rising edge. [R4]
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      queue_full_flag_n_o <= MQF_FLAG_RST;
      queue_full_flag_oe_n_o <= MQF_OE_N_RST;
      queue_empty_flag_n_o <= MQF_FLAG_RST;
      queue_empty_flag_oe_n_o <= MQF_OE_N_RST;
    end
    else
    begin
      queue_full_flag_n_o <= next_full_n;
      queue_full_flag_oe_n_o <= next_full_oe_n;
      queue_empty_flag_n_o <= next_empty_n;
      queue_empty_flag_oe_n_o <= next_empty_oe_n;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic whit_raw;
  logic rhit_raw;
  logic [2:0] strap_raw;
  assign strap_raw = {device_index_strap2_i, device_index_strap1_i,
                      device_index_strap0_i};
  assign whit_raw = write_queue_select_bus_i[SEL_W-1 -: IDX_W] ==
                    strap_raw[IDX_W-1:0];
  assign rhit_raw = read_queue_select_bus_i[SEL_W-1 -: IDX_W] ==
                    strap_raw[IDX_W-1:0];

  full_enable_a: assert property ( // [R9]
    @(posedge clk_i) disable iff (reset_i)
    write_select_strobe_i |->
    ##4 (queue_full_flag_oe_n_o == !$past(whit_raw, 4)))
    else $error("full flag enable does not match write index");

  empty_enable_a: assert property ( // [R14]
    @(posedge clk_i) disable iff (reset_i)
    read_select_strobe_i |->
    ##4 (queue_empty_flag_oe_n_o == !$past(rhit_raw, 4)))
    else $error("empty flag enable does not match read index");

  write_select_a: assert property ( // [R2]
    @(posedge clk_i) disable iff (reset_i)
    write_select_strobe_i |-> ##3 (wsel == $past(write_queue_select_bus_i, 3)))
    else $error("write selection not committed in time");

  read_select_a: assert property ( // [R16]
    @(posedge clk_i) disable iff (reset_i)
    read_select_strobe_i |-> ##3 (rsel == $past(read_queue_select_bus_i, 3)))
    else $error("read selection not committed in time");

  full_keep_a: assert property ( // [R7]
    @(posedge clk_i) disable iff (reset_i)
    (!queue_full_flag_oe_n_o && whit && write_select_strobe_i && whit_raw)
    |-> !queue_full_flag_oe_n_o [*4])
    else $error("full flag released on a switch inside the device");

  empty_keep_a: assert property ( // [R13]
    @(posedge clk_i) disable iff (reset_i)
    (!queue_empty_flag_oe_n_o && rhit && read_select_strobe_i && rhit_raw)
    |-> !queue_empty_flag_oe_n_o [*4])
    else $error("empty flag released on a switch inside the device");

  idle_release_a: assert property ( // [R6]
    @(posedge clk_i) disable iff (reset_i)
    (!wsel_ok && !write_select_strobe_i && !$past(write_select_strobe_i)
     && !$past(write_select_strobe_i, 2)) |-> queue_full_flag_oe_n_o)
    else $error("full flag driven with no queue selected");

  full_level_a: assert property ( // [R17]
    @(posedge clk_i) disable iff (reset_i)
    st.full_w |=> !queue_full_flag_n_o)
    else $error("full flag high for a full queue");

  // A queue with room lets the full flag rise one edge later.
  full_high_a: assert property ( // [R17]
    @(posedge clk_i) disable iff (reset_i)
    !st.full_w |=> queue_full_flag_n_o)
    else $error("full flag low for a queue with room");

  // An empty queue pulls the empty flag low one edge later.
  empty_level_a: assert property ( // [R17]
    @(posedge clk_i) disable iff (reset_i)
    st.empty_r |=> !queue_empty_flag_n_o)
    else $error("empty flag high for an empty queue");

  // A queue holding words lets the empty flag rise one edge later.
  empty_high_a: assert property ( // [R17]
    @(posedge clk_i) disable iff (reset_i)
    !st.empty_r |=> queue_empty_flag_n_o)
    else $error("empty flag low for a queue holding words");

  // With no read selection yet, the empty line stays released.
  read_idle_a: assert property ( // [R12]
    @(posedge clk_i) disable iff (reset_i)
    (!rsel_ok && !read_select_strobe_i && !$past(read_select_strobe_i)
     && !$past(read_select_strobe_i, 2)) |-> queue_empty_flag_oe_n_o)
    else $error("empty flag driven with no queue selected");

  // Ownership of the full line needs a taken write selection first.
  full_free_a: assert property ( // [R6]
    @(posedge clk_i) disable iff (reset_i)
    !wsel_ok |=> queue_full_flag_oe_n_o)
    else $error("full flag driven before any write selection");

  // Ownership of the empty line needs a taken read selection first.
  empty_free_a: assert property ( // [R12]
    @(posedge clk_i) disable iff (reset_i)
    !rsel_ok |=> queue_empty_flag_oe_n_o)
    else $error("empty flag driven before any read selection");

  // A write strobe is taken once it has crossed the pin flops.
  write_owned_a: assert property ( // [R7]
    @(posedge clk_i) disable iff (reset_i)
    write_select_strobe_i |-> ##3 wsel_ok)
    else $error("write selection not taken");

  // A read strobe is taken once it has crossed the pin flops.
  read_owned_a: assert property ( // [R13]
    @(posedge clk_i) disable iff (reset_i)
    read_select_strobe_i |-> ##3 rsel_ok)
    else $error("read selection not taken");
endmodule : mqf_flags

// ==== verification/mqf_ctrl_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// System controller model that drives both queue select ports.
// ---------------------------------------------------------------------------
module mqf_ctrl_model
  import mqf_pkg::*;
(
  input wire logic clk_i,                                // System clock.
  output logic [MQF_SEL_W-1:0] write_queue_select_bus_o, // Write queue.
  output logic write_select_strobe_o,                    // Take write select.
  output logic [MQF_SEL_W-1:0] read_queue_select_bus_o,  // Read queue.
  output logic read_select_strobe_o,                     // Take read select.
  output logic write_word_o,                             // Write one word.
  output logic read_word_o                               // Read one word.
);
  // Idle values at time zero; the buses carry junk until first used.
  initial
  begin
    write_queue_select_bus_o = 8'h5A;
    read_queue_select_bus_o = 8'hA5;
    write_select_strobe_o = 1'b0;
    read_select_strobe_o = 1'b0;
    write_word_o = 1'b0;
    read_word_o = 1'b0;
  end

  // One selection on one port only, so one device owns each line.
  // Between strobes the bus is a don't-care, so it turns to its inverse
  // rather than holding a value the device could wrongly rely on.
  task automatic select(input logic wr, input logic [MQF_SEL_W-1:0] q);
    @(posedge clk_i);
    write_select_strobe_o <= wr;
    read_select_strobe_o <= !wr;
    if (wr)
      write_queue_select_bus_o <= q;
    else
      read_queue_select_bus_o <= q;
    @(posedge clk_i);
    write_select_strobe_o <= 1'b0;
    read_select_strobe_o <= 1'b0;
    write_queue_select_bus_o <= ~write_queue_select_bus_o;
    read_queue_select_bus_o <= ~read_queue_select_bus_o;
  endtask : select

  // A burst of n words, one each edge; callers start it no earlier than the
  // fourth edge after the selection.
  task automatic push(input logic wr, input int n);
    @(posedge clk_i);
    write_word_o <= wr;
    read_word_o <= !wr;
    repeat (n) @(posedge clk_i);
    write_word_o <= 1'b0;
    read_word_o <= 1'b0;
  endtask : push
endmodule : mqf_ctrl_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %0b seen %0b", nm, e, g); end end
// ---------------------------------------------------------------------------
// Self-checking bench for the queue flag block.
// ---------------------------------------------------------------------------
module tb;
  import mqf_pkg::*;
  localparam int DEPTH = 8;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk_i;
  logic reset_i;
  logic [MQF_SEL_W-1:0] wsel;
  logic [MQF_SEL_W-1:0] rsel;
  logic wstb;
  logic rstb;
  logic wword;
  logic rword;
  logic full_n;
  logic full_oe_n;
  logic empty_n;
  logic empty_oe_n;
  int errors;
  int total_checks;
  // Shared flag lines with pull-ups, as on a board with several devices.
  tri1 full_line;
  tri1 empty_line;
  assign full_line = full_oe_n ? 1'bz : full_n;
  assign empty_line = empty_oe_n ? 1'bz : empty_n;

  mqf_ctrl_model ctrl_u (
    .clk_i(clk_i),
    .write_queue_select_bus_o(wsel),
    .write_select_strobe_o(wstb),
    .read_queue_select_bus_o(rsel),
    .read_select_strobe_o(rstb),
    .write_word_o(wword),
    .read_word_o(rword)
  );

  mqf_flags #(.DEPTH(DEPTH)) dut_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .write_queue_select_bus_i(wsel),
    .write_select_strobe_i(wstb),
    .read_queue_select_bus_i(rsel),
    .read_select_strobe_i(rstb),
    .write_word_i(wword),
    .read_word_i(rword),
    .device_index_strap0_i(STRAP[0]),
    .device_index_strap1_i(STRAP[1]),
    .device_index_strap2_i(STRAP[2]),
    .queue_full_flag_n_o(full_n),
    .queue_full_flag_oe_n_o(full_oe_n),
    .queue_empty_flag_n_o(empty_n),
    .queue_empty_flag_oe_n_o(empty_oe_n)
  );

  // ---------------------------------------------------------------------------
  // Shared helpers.
  // ---------------------------------------------------------------------------
  // Waits n edges and lets their updates settle before anything is sampled.
  task automatic at(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : at

  // Selects a queue, then sees the old state on the second edge after and
  // the new one on the third; a released line reads high through its pull-up.
  task automatic switch_chk(input logic wr, input logic [7:0] q,
    input logic old_oe, input logic old_f, input logic new_oe,
    input logic new_f);
    ctrl_u.select(wr, q);
    at(2);
    `CHK("oe_old", old_oe, wr ? full_oe_n : empty_oe_n)
    `CHK("line_old", old_oe | old_f, wr ? full_line : empty_line)
    at(1);
    `CHK("oe_new", new_oe, wr ? full_oe_n : empty_oe_n)
    `CHK("line_new", new_oe | new_f, wr ? full_line : empty_line)
  endtask : switch_chk

  // Moves n words and expects the selected flag to fall four edges after
  // the last one, not three.
  task automatic burst_chk(input logic wr, input int n);
    ctrl_u.push(wr, n);
    at(3);
    `CHK("line_before", 1'b1, wr ? full_line : empty_line)
    at(1);
    `CHK("line_after", 1'b0, wr ? full_line : empty_line)
  endtask : burst_chk

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  // Ownership of the write line follows the top select bits.
  task automatic t_write_sel();
    `CHK("full_oe_rst", 1'b1, full_oe_n)
    `CHK("empty_oe_rst", 1'b1, empty_oe_n)
    switch_chk(1'b1, 8'hA3, 1'b1, 1'b1, 1'b0, 1'b1);
    switch_chk(1'b1, 8'h83, 1'b0, 1'b1, 1'b1, 1'b1);
    switch_chk(1'b1, 8'hA3, 1'b1, 1'b1, 1'b0, 1'b1);
  endtask : t_write_sel

  // Filling a queue, then switching away and back within the device.
  task automatic t_fill();
    at(2);
    burst_chk(1'b1, DEPTH);
    switch_chk(1'b1, 8'hA4, 1'b0, 1'b0, 1'b0, 1'b1);
    switch_chk(1'b1, 8'hA3, 1'b0, 1'b1, 1'b0, 1'b0);
  endtask : t_fill

  // Read side ownership, empty status per queue, and a read that frees a
  // full queue while another one is write-selected.
  task automatic t_read();
    switch_chk(1'b0, 8'hA3, 1'b1, 1'b1, 1'b0, 1'b1);
    switch_chk(1'b0, 8'hA5, 1'b0, 1'b1, 1'b0, 1'b0);
    switch_chk(1'b0, 8'h83, 1'b0, 1'b0, 1'b1, 1'b1);
    switch_chk(1'b0, 8'hA3, 1'b1, 1'b1, 1'b0, 1'b1);
    switch_chk(1'b1, 8'hA4, 1'b0, 1'b0, 1'b0, 1'b1);
    ctrl_u.push(1'b0, 1);
    at(4);
    switch_chk(1'b1, 8'hA3, 1'b0, 1'b1, 1'b0, 1'b1);
  endtask : t_read

  // Draining the rest of the queue drops the empty flag.
  task automatic t_drain();
    burst_chk(1'b0, DEPTH - 1);
  endtask : t_drain

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // Free-running 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Main sequence: sixteen cycles of reset, then the scenarios in order.
  initial
  begin
    errors = 0;
    total_checks = 0;
    reset_i = 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    at(1);
    t_write_sel();
    t_fill();
    t_read();
    t_drain();
    summarize();
  end

  // The scenarios need about a hundred cycles; the 5000-cycle limit lies far beyond that, so reaching it is a hang.
  initial
  begin
    #50000;
    errors++;
    summarize();
  end
endmodule : tb
